// ### hdl/core_debug_entry_control.v
// Run-control debug entry logic: status to the debug module, PC redirect,
// ebreak handling, debug/trigger register access guard.
// Assumes the pipeline reports decode-stage events as one-cycle strobes.
`timescale 1ns/1ps
`include "debug_entry_consts.vh"
module core_debug_entry_control #(
   parameter NUM_TRIGGERS = 1
) (
   clk_sys,
   rst,
   fetch_enable,
   debug_req,
   halt_entry_address_in,
   debug_exception_address_in,
   trap_vector_base,
   decode_valid,
   decode_pc,
   decode_ebreak,
   decode_xret,
   decode_exception,
   decode_dbg_csr_access,
   decode_trig_csr_access,
   decode_trig_csr_write,
   trigger_match,
   trigger_action_field,
   ebreakm_write,
   ebreakm_wdata,
   debug_havereset,
   debug_running,
   debug_halted,
   pc_set,
   pc_target,
   kill_decode,
   illegal_csr,
   trigger_write_en,
   debug_mode,
   ebreakm,
   debug_return_pc,
   debug_cause,
   trap_return_pc,
   trap_cause,
   trap_cause_write
);
   input wire clk_sys;
   input wire rst;
   input wire fetch_enable;
   input wire debug_req;
   input wire [31:0] halt_entry_address_in;
   input wire [31:0] debug_exception_address_in;
   input wire [31:0] trap_vector_base;
   input wire decode_valid;
   input wire [31:0] decode_pc;
   input wire decode_ebreak;
   input wire decode_xret;
   input wire decode_exception;
   input wire decode_dbg_csr_access;
   input wire decode_trig_csr_access;
   input wire decode_trig_csr_write;
   input wire trigger_match;
   input wire [3:0] trigger_action_field;
   input wire ebreakm_write;
   input wire ebreakm_wdata;
   output reg debug_havereset;
   output reg debug_running;
   output reg debug_halted;
   output reg pc_set;
   output reg [31:0] pc_target;
   output reg kill_decode;
   output reg illegal_csr;
   output reg trigger_write_en;
   output wire debug_mode;
   output reg ebreakm;
   output reg [31:0] debug_return_pc;
   output reg [2:0] debug_cause;
   output reg [31:0] trap_return_pc;
   output reg [5:0] trap_cause;
   output reg trap_cause_write;

   ////////////////////////////////////////////////////////////////////////////
   // Debug state
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [1:0] wait_cnt_reg;
   reg req_pending_reg;
   reg dmode_next;
   wire fetch_seen;
   wire trig_fire;
   wire ebreak_to_debug;
   wire entry;
   wire entry_from_run;
   wire [2:0] entry_cause;
   wire illegal_access_now;
   wire ebreak_in_debug;
   wire exc_in_debug;
   wire trap_outside;

   // Debug mode flag kept in a leaf flop; drives the output directly
   status_flop #(
      .RESET_VALUE(1'b0)
   ) u_dmode (
      .clk_sys(clk_sys),
      .rst(rst),
      .d(dmode_next),
      .q(debug_mode)
   );

   // Fetch permit latched so a brief pulse still starts the core
   status_flop #(
      .RESET_VALUE(1'b0)
   ) u_fetch_seen (
      .clk_sys(clk_sys),
      .rst(rst),
      .d(fetch_seen | fetch_enable),
      .q(fetch_seen)
   );

   // Debug entry sources
   assign trig_fire = trigger_match & (trigger_action_field == `ACTION_DEBUG);
   assign ebreak_to_debug = decode_valid & decode_ebreak & ~debug_mode & ebreakm;
   // Halt request honoured in the cycle it is first seen; the decoding
   // instruction is killed rather than retired
   assign entry_from_run = (state_reg == `DS_RUN) & ~debug_mode &
      (debug_req | req_pending_reg | trig_fire | ebreak_to_debug);
   assign entry = entry_from_run |
      ((state_reg == `DS_WAIT) & (wait_cnt_reg == `HAVERESET_CYCLES) &
       (debug_req | req_pending_reg));
   // Cause codes follow priority: ebreak, then trigger, then halt request
   assign entry_cause = ebreak_to_debug ? `CAUSE_EBREAK :
      (trig_fire ? `CAUSE_TRIGGER : `CAUSE_HALTREQ);

   ////////////////////////////////////////////////////////////////////////////
   // Register access guard and lower-priority redirects
   assign illegal_access_now = (decode_dbg_csr_access & ~debug_mode) |
      (decode_trig_csr_access & (NUM_TRIGGERS == 0));

   // Entry outranks all of these; they only act when no entry is taken
   assign ebreak_in_debug = debug_mode & decode_valid & decode_ebreak;
   assign exc_in_debug = debug_mode & decode_valid &
      (decode_xret | decode_exception | illegal_access_now);
   // With the select clear an ebreak traps; so does a refused register access
   assign trap_outside = ~debug_mode & decode_valid &
      (decode_ebreak | illegal_access_now);

   ////////////////////////////////////////////////////////////////////////////
   // State machine
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `DS_RESET: begin
            // Wait for the fetch permit; requests meanwhile are remembered
            if (fetch_seen | fetch_enable) begin
               state_next = `DS_WAIT;
            end
         end
         `DS_WAIT: begin
            // A request remembered since release halts straight from here
            if (wait_cnt_reg == `HAVERESET_CYCLES) begin
               state_next = entry ? `DS_HALT : `DS_RUN;
            end
         end
         `DS_RUN: begin
            // Halt request, trigger match or ebreak with the select set
            if (entry) begin
               state_next = `DS_HALT;
            end
         end
         `DS_HALT: begin
            // No resume path here: leaving debug mode is handled outside
            state_next = `DS_HALT;
         end
         default: begin
            state_next = `DS_RESET;
         end
      endcase
   end

   // Debug mode is only entered here; resume lies outside this block
   always @* begin
      dmode_next = debug_mode;
      if (entry) begin
         dmode_next = 1'b1;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= `DS_RESET;
         wait_cnt_reg <= `WAIT_CNT_START;
         req_pending_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == `DS_WAIT) begin
            // Counter stops at its end value so WAIT is left exactly once
            if (wait_cnt_reg != `HAVERESET_CYCLES) begin
               wait_cnt_reg <= wait_cnt_reg + `WAIT_CNT_STEP;
            end
         end
         // A request seen before the core can honour it is remembered
         if (entry) begin
            req_pending_reg <= 1'b0;
         end else if (debug_req & ~debug_mode) begin
            req_pending_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status outputs, one-hot from the state
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         debug_havereset <= 1'b1;
         debug_running <= 1'b0;
         debug_halted <= 1'b0;
      end else begin
         // Registered from state_next so the three levels switch on one edge
         debug_havereset <= (state_next == `DS_RESET) | (state_next == `DS_WAIT);
         debug_running <= (state_next == `DS_RUN);
         debug_halted <= (state_next == `DS_HALT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Redirects, debug and trap registers
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pc_set <= 1'b0;
         pc_target <= `ZERO32;
         kill_decode <= 1'b0;
         ebreakm <= `EBREAKM_RESET;
         debug_return_pc <= `ZERO32;
         debug_cause <= `CAUSE_NONE;
         trap_return_pc <= `ZERO32;
         trap_cause <= `MCAUSE_NONE;
         trap_cause_write <= 1'b0;
      end else begin
         // Target holds between pulses; only pc_set marks a redirect
         pc_set <= 1'b0;
         kill_decode <= 1'b0;
         trap_cause_write <= 1'b0;
         if (entry) begin
            pc_set <= 1'b1;
            pc_target <= halt_entry_address_in;
            kill_decode <= decode_valid;
            debug_return_pc <= decode_pc;
            debug_cause <= entry_cause;
         end else if (ebreak_in_debug) begin
            // Restart the debug code; no debug or trap register moves
            pc_set <= 1'b1;
            pc_target <= halt_entry_address_in;
         end else if (exc_in_debug) begin
            // Stays in debug mode; status registers are left as they are
            pc_set <= 1'b1;
            pc_target <= debug_exception_address_in;
         end else if (trap_outside) begin
            // Trap value is not captured; handlers size the ebreak themselves
            pc_set <= 1'b1;
            pc_target <= trap_vector_base;
            trap_return_pc <= decode_pc;
            trap_cause <= decode_ebreak ? `MCAUSE_BREAKPOINT : `MCAUSE_ILLEGAL;
            trap_cause_write <= 1'b1;
         end
         // Select writable only from debug mode, so first entry needs another route
         if (debug_mode & ebreakm_write) begin
            ebreakm <= ebreakm_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Guard pulses; a killed instruction raises no illegal access
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         illegal_csr <= 1'b0;
         trigger_write_en <= 1'b0;
      end else begin
         illegal_csr <= decode_valid & illegal_access_now & ~entry;
         // Write guard tied high: trigger data is written only from debug mode
         trigger_write_en <= decode_valid & decode_trig_csr_write & (NUM_TRIGGERS != 0) &
            (debug_mode | ~`WRITE_GUARD_TIED);
      end
   end
endmodule // core_debug_entry_control

// ### hdl/debug_entry_consts.vh
// Constants for the core debug entry control block.
// Assumes inclusion by bare name from the design files.
`ifndef DEBUG_ENTRY_CONSTS_VH
`define DEBUG_ENTRY_CONSTS_VH
`define DS_RESET 2'h0
`define DS_WAIT 2'h1
`define DS_RUN 2'h2
`define DS_HALT 2'h3
`define CAUSE_NONE 3'h0
`define CAUSE_EBREAK 3'h1
`define CAUSE_TRIGGER 3'h2
`define CAUSE_HALTREQ 3'h3
`define MCAUSE_BREAKPOINT 6'h03
`define MCAUSE_ILLEGAL 6'h02
`define HAVERESET_CYCLES 2'h2
`define EBREAKM_RESET 1'b0
`define WRITE_GUARD_TIED 1'b1
`define ACTION_DEBUG 4'h1
`define ZERO32 32'h00000000
`define MCAUSE_NONE 6'h00
`define WAIT_CNT_START 2'h0
`define WAIT_CNT_STEP 2'h1
`endif

// ### hdl/status_flop.v
// One-bit status flip-flop with asynchronous reset to a constant.
// Assumes a single clock domain.
`timescale 1ns/1ps
module status_flop #(
   parameter RESET_VALUE = 1'b0
) (
   clk_sys,
   rst,
   d,
   q
);
   input wire clk_sys;
   input wire rst;
   input wire d;
   output reg q;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= RESET_VALUE;
      end else begin
         q <= d;
      end
   end
endmodule // status_flop

// ### verif/debug_module_model.sv
// Debug module stand-in that raises the halt request.
// Assumes the core clock and reset; go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
module debug_module_model (
   input wire clk_sys,
   input wire rst,
   input wire go,
   input wire debug_halted,
   output reg debug_req
);
   // Held until halted is seen, so a core that is still unavailable cannot miss it
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         debug_req <= 1'b0;
      else if (debug_halted)
         debug_req <= 1'b0;
      else if (go)
         debug_req <= 1'b1;
   end
endmodule // debug_module_model

// ### verif/core_debug_entry_control_monitor.sv
// Checker on the debug entry control ports.
// Assumes one clock clk_sys and asynchronous active-high rst.
`timescale 1ns/1ps
module core_debug_entry_control_monitor (
   input wire clk_sys,
   input wire rst,
   input wire fetch_enable,
   input wire debug_req,
   input wire [31:0] halt_entry_address_in,
   input wire [31:0] debug_exception_address_in,
   input wire [31:0] trap_vector_base,
   input wire decode_valid,
   input wire decode_ebreak,
   input wire decode_xret,
   input wire decode_exception,
   input wire decode_dbg_csr_access,
   input wire debug_havereset,
   input wire debug_running,
   input wire debug_halted,
   input wire pc_set,
   input wire [31:0] pc_target,
   input wire kill_decode,
   input wire illegal_csr,
   input wire ebreakm,
   input wire trigger_write_en,
   input wire debug_mode,
   input wire [2:0] debug_cause,
   input wire [5:0] trap_cause,
   input wire trap_cause_write
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_status_onehot: assert property (
      $onehot({debug_havereset, debug_running, debug_halted})) else $error("status not one-hot");
   chk_reset_hold: assert property (
      debug_havereset && !fetch_enable |=> debug_havereset) else $error("reset-seen left early");
   chk_mode_status: assert property (
      !debug_havereset |-> debug_halted == debug_mode) else $error("halted differs from mode");
   chk_req_halt: assert property (
      debug_running && debug_req |-> ##1 debug_halted && pc_set
      && pc_target == halt_entry_address_in) else $error("halt request not taken");
   chk_ebreak_debug: assert property (
      debug_mode && decode_valid && decode_ebreak |=> pc_set
      && pc_target == halt_entry_address_in && $stable(debug_cause)) else $error("ebreak in debug");
   chk_exc_debug: assert property (
      debug_mode && decode_valid && (decode_xret || decode_exception) |=> pc_set
      && pc_target == debug_exception_address_in && !trap_cause_write) else $error("debug exc");
   chk_ebreak_trap: assert property (
      debug_running && !debug_req && !ebreakm && decode_valid && decode_ebreak
      |=> trap_cause_write
      && trap_cause == 6'h03 && pc_target == trap_vector_base && debug_running)
      else $error("ebreak trap wrong");
   chk_trig_guard: assert property (
      trigger_write_en |-> debug_mode) else $error("trigger write outside debug");
   chk_kill_decode: assert property (
      debug_running && debug_req && decode_valid |=> kill_decode && !trap_cause_write)
      else $error("decoding instruction not killed");
   chk_dbg_guard: assert property (
      decode_valid && decode_dbg_csr_access && !debug_mode && !debug_req |=> illegal_csr)
      else $error("debug register access not refused");
   cov_req_run: cover property (debug_running && debug_req);
   cov_early_halt: cover property ($fell(debug_havereset) && debug_halted);
   cov_trap: cover property (trap_cause_write);
endmodule // core_debug_entry_control_monitor
bind core_debug_entry_control core_debug_entry_control_monitor core_debug_entry_control_monitor_i (.*);

// ### verif/test_core_debug_entry_control.sv
// Self-checking bench for the debug entry control block.
// Assumes the design files and the halt request model are compiled first.
`timescale 1ns/1ps
module test_core_debug_entry_control;
   localparam [31:0] HALT_A = 32'h00001a00;
   localparam [31:0] EXC_A = 32'h00001b00;
   localparam [31:0] TVEC = 32'h00000100;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg fetch_enable = 1'b0;
   reg go = 1'b0;
   reg dv = 1'b1;
   reg [7:0] strb = 8'h00;
   reg [3:0] act = 4'h0;
   reg [31:0] pc = 32'h00000440;
   reg saw_run = 1'b0;
   wire debug_req, debug_havereset, debug_running, debug_halted, pc_set, kill_decode;
   wire illegal_csr, trigger_write_en, debug_mode, ebreakm, trap_cause_write;
   wire [31:0] pc_target, debug_return_pc, trap_return_pc;
   wire [2:0] debug_cause;
   wire [5:0] trap_cause;
   integer errors = 0;
   integer n_compared = 0;
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (debug_running) saw_run <= 1'b1;
   debug_module_model debug_module_model_i (.clk_sys(clk_sys), .rst(rst), .go(go),
      .debug_halted(debug_halted), .debug_req(debug_req));
   core_debug_entry_control core_debug_entry_control_i (.clk_sys(clk_sys), .rst(rst),
      .fetch_enable(fetch_enable), .debug_req(debug_req), .halt_entry_address_in(HALT_A),
      .debug_exception_address_in(EXC_A), .trap_vector_base(TVEC), .decode_valid(dv),
      .decode_pc(pc), .decode_ebreak(strb[5]), .decode_xret(strb[4]), .decode_exception(strb[3]),
      .decode_dbg_csr_access(strb[2]), .decode_trig_csr_access(strb[1]),
      .decode_trig_csr_write(strb[0]), .trigger_match(strb[7]), .trigger_action_field(act),
      .ebreakm_write(strb[6]), .ebreakm_wdata(1'b1), .debug_havereset(debug_havereset),
      .debug_running(debug_running), .debug_halted(debug_halted), .pc_set(pc_set),
      .pc_target(pc_target), .kill_decode(kill_decode), .illegal_csr(illegal_csr),
      .trigger_write_en(trigger_write_en), .debug_mode(debug_mode), .ebreakm(ebreakm),
      .debug_return_pc(debug_return_pc), .debug_cause(debug_cause),
      .trap_return_pc(trap_return_pc), .trap_cause(trap_cause),
      .trap_cause_write(trap_cause_write));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One-cycle decode strobe; results land at the following edge
   task op(input [7:0] v);
      begin
         @(posedge clk_sys) strb <= v;
         @(posedge clk_sys) strb <= 8'h00;
         #1;
      end
   endtask
   task wait_st(input [2:0] st);
      integer i;
      begin
         for (i = 0; i < 20 && {debug_havereset, debug_running, debug_halted} !== st; i = i + 1)
            @(posedge clk_sys) #1;
         chk({debug_havereset, debug_running, debug_halted}, st);
      end
   endtask
   task do_reset(input early);
      begin
         @(posedge clk_sys) rst <= 1'b1;
         fetch_enable <= 1'b0;
         repeat (20) @(posedge clk_sys);
         chk({debug_havereset, debug_running, debug_halted}, 3'b100);
         rst <= 1'b0;
         saw_run <= 1'b0;
         repeat (3) @(posedge clk_sys);
         go <= early;
         @(posedge clk_sys) go <= 1'b0;
         repeat (6) @(posedge clk_sys);
         chk(debug_havereset, 1'b1);
         fetch_enable <= 1'b1;
      end
   endtask
   task print_verdict;
      begin
         $display("compared %0d mismatches %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      repeat (2000) @(posedge clk_sys);
      errors = errors + 1;
      print_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset(1'b0);
      wait_st(3'b010);
      op(8'h20);
      chk({trap_cause_write, trap_cause}, 7'h43);
      chk(trap_return_pc, 32'h00000440);
      chk(pc_target, TVEC);
      op(8'h04);
      chk({illegal_csr, trap_cause}, 7'h42);
      op(8'h41);
      chk({ebreakm, trigger_write_en, debug_running}, 3'b001);
      dv <= 1'b0;
      op(8'h20);
      chk({pc_set, trap_cause_write}, 2'b00);
      dv <= 1'b1;
      $display("test trap outside debug done");
      @(posedge clk_sys) pc <= 32'h00000884;
      go <= 1'b1;
      @(posedge clk_sys) go <= 1'b0;
      wait_st(3'b001);
      chk({pc_set, kill_decode, debug_cause}, 5'h1b);
      chk(pc_target, HALT_A);
      chk(debug_return_pc, 32'h00000884);
      $display("test running and halt request done");
      op(8'h40);
      chk(ebreakm, 1'b1);
      op(8'h10);
      chk(pc_target, EXC_A);
      chk({trap_cause_write, debug_cause}, 4'h3);
      op(8'h20);
      chk(pc_target, HALT_A);
      chk({debug_cause, debug_mode}, 4'h7);
      op(8'h08);
      chk(pc_target, EXC_A);
      chk(debug_halted, 1'b1);
      op(8'h03);
      chk(trigger_write_en, 1'b1);
      op(8'h04);
      chk(illegal_csr, 1'b0);
      $display("test debug mode done");
      do_reset(1'b1);
      wait_st(3'b001);
      chk(saw_run, 1'b0);
      $display("test early request done");
      do_reset(1'b0);
      wait_st(3'b010);
      op(8'h80);
      chk(debug_running, 1'b1);
      @(posedge clk_sys) act <= 4'h1;
      op(8'h80);
      wait_st(3'b001);
      chk(debug_cause, 3'h2);
      $display("test trigger entry done");
      print_verdict;
   end
endmodule // test_core_debug_entry_control
